// ---- design/csw_pkg.sv ----
// constants shared by the channel sense and wake block
package csw_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned LOW_POWER_OSC_HZ = 32000;
	localparam int unsigned LOW_POWER_OSC_DIV = CLK_HZ / LOW_POWER_OSC_HZ;
	localparam int unsigned CAL_PERIOD_TICKS = 32000;
	localparam int unsigned CAL_WINDOW_TICKS = 32;
	localparam int unsigned CAL_TOL_PCT = 1;
	localparam int unsigned SLEEP_W = 38;
	localparam int signed RSSI_MIN_DBM = -127;
	localparam int signed RSSI_MAX_DBM = 20;
	localparam int unsigned JUMP_WIN_BASE = 1;
	localparam int unsigned SNR_MIN_DB = 7;
	localparam logic [1:0] DEMOD_2FSK = 2'h1;
	localparam logic [1:0] DEMOD_OOK = 2'h0;
	localparam logic [1:0] DEMOD_4FSK = 2'h2;
	localparam logic [2:0] ST_SLEEP = 3'h1;
	localparam logic [2:0] ST_STANDBY_STATE = 3'h2;
	localparam logic [2:0] ST_RFS = 3'h3;
	localparam logic [2:0] ST_TFS = 3'h4;
	localparam logic [2:0] ST_RX = 3'h5;
	localparam logic [2:0] ST_TX = 3'h6;
	typedef enum logic [1:0] {
		CSW_CAL_IDLE = 2'b00,
		CSW_CAL_RUN = 2'b01,
		CSW_CAL_DONE = 2'b10
	} csw_cal_e;
endpackage

// ---- design/csw_channel_sense.sv ----
// channel sensing, supply check, sleep wake timer and phase jump detector
// Operation
// - sleep timer ticks from a nominal 32 kHz low-power oscillator
// - enabled timer wakes from sleep each programmed interval
// - oscillator calibrated at power-up and periodically, to within 1 tick of the 32-tick target
// - one supply check per tuning, result readable
// - tuning when sleep or standby moves to synth, tx or rx
// - strength reported from -127 dBm to +20 dBm
// - setting picks live strength or latched per packet stage
// - flag high when live strength exceeds threshold, else low
// - strength flag feeds signal-valid interrupt and super-low-power mode
// - detector works only in 2-FSK demodulation
// - each change of symbol value counts one jump, until the count saturates at 15
// - two-bit window select sets jumps needed for decision
// - detector also checks deviation valid and snr above 7 dB
// - detector output high only when rate, deviation and snr good
// - detector output selectable for interrupt or receive extension
// - direct mode with mute set silences data without wanted signal, in 2-FSK only
// - direct mode sends demodulator data to the data output pin
`timescale 1ns/1ns
module csw_channel_sense #(
	parameter int unsigned SLEEP_W = csw_pkg::SLEEP_W,
	parameter int unsigned LOW_POWER_OSC_DIV = csw_pkg::LOW_POWER_OSC_DIV,
	parameter int unsigned CAL_PERIOD_TICKS = csw_pkg::CAL_PERIOD_TICKS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sleep_timer_en,
	input wire logic [SLEEP_W-1:0] sleep_interval,
	input wire logic [2:0] chip_state,
	input wire logic supply_low_in,
	input wire logic signed [7:0] rssi_in,
	input wire logic strength_capture_mode,
	input wire logic packet_stage_strobe,
	input wire logic signed [7:0] strength_threshold,
	input wire logic [1:0] demod_type,
	input wire logic demod_symbol,
	input wire logic symbol_strobe,
	input wire logic deviation_ok,
	input wire logic [5:0] snr_db,
	input wire logic [1:0] jump_window_select,
	input wire logic valid_irq_src_sel,
	input wire logic slp_ext_src_sel,
	input wire logic direct_mode,
	input wire logic dout_mute,
	input wire logic [7:0] osc_measured_ticks,
	output logic wake_event,
	output logic cal_busy,
	output logic [7:0] osc_trim,
	output logic supply_level_result,
	output logic signed [7:0] strength_value,
	output logic strength_above,
	output logic phase_jump_detector,
	output logic signal_valid_irq,
	output logic slp_rx_extend,
	output logic demod_data_out
);
	localparam logic [7:0] TRIM_MID = 8'h80;
	localparam logic [7:0] CAL_TARGET = 8'(csw_pkg::CAL_WINDOW_TICKS);
	localparam logic [7:0] CAL_TOL = 8'(csw_pkg::CAL_TOL_PCT);
	localparam logic [5:0] SNR_MIN = 6'(csw_pkg::SNR_MIN_DB);
	localparam logic signed [7:0] RSSI_LO = 8'(csw_pkg::RSSI_MIN_DBM);
	localparam logic signed [7:0] RSSI_HI = 8'(csw_pkg::RSSI_MAX_DBM);
	localparam logic [15:0] DIV_LAST = 16'(LOW_POWER_OSC_DIV - 1);
	localparam logic [15:0] CAL_LAST = 16'(CAL_PERIOD_TICKS - 1);

	typedef struct packed {
		logic [15:0] div_cnt;
		logic lp_tick;
		logic [SLEEP_W-1:0] sleep_cnt;
		logic wake;
		csw_pkg::csw_cal_e cal_state;
		logic busy;
		logic [15:0] cal_cnt;
		logic [7:0] trim;
		logic [2:0] prev_state;
		logic sup_s1;
		logic sup_s2;
		logic supply_result;
		logic signed [7:0] strength;
		logic above;
		logic sym_s1;
		logic sym_s2;
		logic last_sym;
		logic have_sym;
		logic [3:0] jumps;
		logic detect;
		logic irq;
		logic slp_ext;
		logic dout;
	} csw_state_s;

	csw_state_s cur;
	csw_state_s next_cur;
	logic tuning;
	logic fresh_rx;
	logic in_2fsk;
	logic [3:0] jumps_needed;
	logic jump_now;
	logic [3:0] jumps_after;
	logic signed [7:0] rssi_clamped;
	logic quality_ok;

	always_comb begin
		next_cur = cur;
		// slower rate as a one-cycle enable, no second clock domain
		next_cur.lp_tick = 1'b0;
		if (cur.div_cnt == DIV_LAST) begin
			next_cur.div_cnt = '0;
			next_cur.lp_tick = 1'b1;
		end else begin
			next_cur.div_cnt = cur.div_cnt + 16'h0001;
		end

		// sleep timer: counts only in sleep, wake pulse then reload
		next_cur.wake = 1'b0;
		if (!sleep_timer_en || chip_state != csw_pkg::ST_SLEEP) begin
			next_cur.sleep_cnt = sleep_interval;
		end else if (cur.lp_tick) begin
			if (cur.sleep_cnt <= SLEEP_W'(1)) begin
				next_cur.wake = 1'b1;
				next_cur.sleep_cnt = sleep_interval;
			end else begin
				next_cur.sleep_cnt = cur.sleep_cnt - SLEEP_W'(1);
			end
		end

		// calibration: first pass at power-up, then every period
		case (cur.cal_state)
			csw_pkg::CSW_CAL_RUN: begin
				if (cur.lp_tick) begin
					// one trim step per tick until within tolerance
					if (osc_measured_ticks > CAL_TARGET + CAL_TOL) begin
						next_cur.trim = cur.trim - 8'h01;
					end else if (osc_measured_ticks + CAL_TOL < CAL_TARGET) begin
						next_cur.trim = cur.trim + 8'h01;
					end else begin
						next_cur.cal_state = csw_pkg::CSW_CAL_DONE;
						next_cur.cal_cnt = '0;
					end
				end
			end
			csw_pkg::CSW_CAL_DONE: begin
				if (cur.lp_tick) begin
					if (cur.cal_cnt == CAL_LAST) begin
						next_cur.cal_state = csw_pkg::CSW_CAL_RUN;
					end else begin
						next_cur.cal_cnt = cur.cal_cnt + 16'h0001;
					end
				end
			end
			default: begin
				next_cur.cal_state = csw_pkg::CSW_CAL_RUN;
			end
		endcase
		// busy flag registered so the output comes straight from a flop
		next_cur.busy = (next_cur.cal_state != csw_pkg::CSW_CAL_DONE);

		// supply check sampled on each tuning transition
		next_cur.prev_state = chip_state;
		next_cur.sup_s1 = supply_low_in;
		next_cur.sup_s2 = cur.sup_s1;
		if (tuning) begin
			next_cur.supply_result = cur.sup_s2;
		end

		// strength readout
		if (!strength_capture_mode || packet_stage_strobe) begin
			next_cur.strength = rssi_clamped;
		end
		next_cur.above = rssi_clamped > strength_threshold;

		// phase jump detector
		next_cur.sym_s1 = demod_symbol;
		next_cur.sym_s2 = cur.sym_s1;
		if (!in_2fsk || fresh_rx) begin
			next_cur.jumps = '0;
			next_cur.detect = 1'b0;
			next_cur.have_sym = 1'b0;
		end else if (symbol_strobe) begin
			next_cur.last_sym = cur.sym_s2;
			next_cur.have_sym = 1'b1;
			// decision uses the count including this jump, so no one-symbol lag
			next_cur.jumps = jumps_after;
			next_cur.detect = (jumps_after >= jumps_needed) && quality_ok;
		end

		next_cur.irq = valid_irq_src_sel ? cur.detect : cur.above;
		next_cur.slp_ext = slp_ext_src_sel ? cur.detect : cur.above;

		// direct mode path, mute gates while no wanted signal, in 2-FSK only
		if (!direct_mode) begin
			next_cur.dout = 1'b0;
		end else if (dout_mute && in_2fsk && !cur.detect) begin
			next_cur.dout = 1'b0;
		end else begin
			next_cur.dout = cur.sym_s2;
		end
	end

	always_comb begin
		tuning = (cur.prev_state == csw_pkg::ST_SLEEP || cur.prev_state == csw_pkg::ST_STANDBY_STATE)
			&& (chip_state == csw_pkg::ST_RFS || chip_state == csw_pkg::ST_TFS
			|| chip_state == csw_pkg::ST_RX || chip_state == csw_pkg::ST_TX);
		fresh_rx = (chip_state == csw_pkg::ST_RX) && (cur.prev_state != csw_pkg::ST_RX);
		in_2fsk = (demod_type == csw_pkg::DEMOD_2FSK);
		// equal neighbours are not a jump; count saturates instead of wrapping
		jump_now = cur.have_sym && (cur.sym_s2 != cur.last_sym);
		jumps_after = (jump_now && cur.jumps != 4'hf) ? cur.jumps + 4'h1 : cur.jumps;
		// window codes 0..3 ask for 1,2,4,8 jumps; 4 is the sensible default
		jumps_needed = 4'(csw_pkg::JUMP_WIN_BASE) << jump_window_select;
		quality_ok = deviation_ok && (snr_db > SNR_MIN);
		if (rssi_in < RSSI_LO) begin
			rssi_clamped = RSSI_LO;
		end else if (rssi_in > RSSI_HI) begin
			rssi_clamped = RSSI_HI;
		end else begin
			rssi_clamped = rssi_in;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cur <= '0;
			cur.trim <= TRIM_MID;
			cur.cal_state <= csw_pkg::CSW_CAL_IDLE;
			cur.busy <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// host must reconfigure after power-on reset; all state returns to defaults
	assign wake_event = cur.wake;
	assign cal_busy = cur.busy;
	assign osc_trim = cur.trim;
	assign supply_level_result = cur.supply_result;
	assign strength_value = cur.strength;
	assign strength_above = cur.above;
	assign phase_jump_detector = cur.detect;
	assign signal_valid_irq = cur.irq;
	assign slp_rx_extend = cur.slp_ext;
	assign demod_data_out = cur.dout;

	AST_WAKE_ONLY_SLEEP: assert property (@(posedge mclk) disable iff (rst)
		cur.wake |-> $past(chip_state) == csw_pkg::ST_SLEEP && sleep_timer_en)
		else $error("wake outside sleep");
	AST_RELOAD: assert property (@(posedge mclk) disable iff (rst)
		cur.wake |-> cur.sleep_cnt == $past(sleep_interval))
		else $error("interval not reloaded");
	AST_TICK: assert property (@(posedge mclk) disable iff (rst)
		cur.lp_tick |=> !cur.lp_tick)
		else $error("tick longer than one cycle");
	AST_ABOVE: assert property (@(posedge mclk) disable iff (rst)
		!rst |=> cur.above == ($past(rssi_clamped) > $past(strength_threshold)))
		else $error("compare flag wrong");
	AST_NO_DETECT_OFF_2FSK: assert property (@(posedge mclk) disable iff (rst)
		!in_2fsk |=> !cur.detect)
		else $error("detector active off 2-FSK");
	AST_DETECT_QUALITY: assert property (@(posedge mclk) disable iff (rst)
		$rose(cur.detect) |-> $past(quality_ok) && $past(jumps_after) >= $past(jumps_needed))
		else $error("detect without quality");
	AST_FRESH: assert property (@(posedge mclk) disable iff (rst)
		fresh_rx |=> cur.jumps == 4'h0 && !cur.detect)
		else $error("detector not cleared");
	AST_MUTE: assert property (@(posedge mclk) disable iff (rst)
		direct_mode && dout_mute && in_2fsk && !cur.detect |=> !demod_data_out)
		else $error("muted output toggled");
	AST_SUPPLY: assert property (@(posedge mclk) disable iff (rst)
		!tuning |=> $stable(supply_level_result))
		else $error("supply result changed without tuning");
	AST_RANGE: assert property (@(posedge mclk) disable iff (rst)
		strength_value >= RSSI_LO && strength_value <= RSSI_HI)
		else $error("strength out of span");

	// named steps of the detector: a strobe that the detector accepts, then what it saw
	sequence seq_det_step;
		symbol_strobe && in_2fsk && !fresh_rx;
	endsequence
	sequence seq_jump_step;
		seq_det_step ##0 (jump_now && cur.jumps != 4'hf);
	endsequence
	sequence seq_same_step;
		seq_det_step ##0 !jump_now;
	endsequence
	sequence seq_window_met;
		seq_det_step ##0 (jumps_after >= jumps_needed && quality_ok);
	endsequence
	sequence seq_window_short;
		seq_det_step ##0 (jumps_after < jumps_needed || !quality_ok);
	endsequence
	// tuning is one step: leaving sleep or standby for an active state
	sequence seq_tune;
		!rst && tuning;
	endsequence

	AST_JUMP_COUNT: assert property (@(posedge mclk) disable iff (rst)
		seq_jump_step |=> cur.jumps == $past(cur.jumps) + 4'h1)
		else $error("jump not counted");
	AST_NO_JUMP_SAME: assert property (@(posedge mclk) disable iff (rst)
		seq_same_step |=> $stable(cur.jumps))
		else $error("equal symbols counted");
	AST_WINDOW_MET: assert property (@(posedge mclk) disable iff (rst)
		seq_window_met |=> phase_jump_detector)
		else $error("window met but no detect");
	AST_WINDOW_SHORT: assert property (@(posedge mclk) disable iff (rst)
		seq_window_short |=> !phase_jump_detector)
		else $error("detect without window or quality");
	AST_TUNE_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
		seq_tune |=> supply_level_result == $past(cur.sup_s2))
		else $error("supply not sampled on tuning");
	AST_IRQ_SRC: assert property (@(posedge mclk) disable iff (rst)
		!rst |=> signal_valid_irq
		== ($past(valid_irq_src_sel) ? $past(cur.detect) : $past(cur.above)))
		else $error("irq source wrong");
	AST_SLP_SRC: assert property (@(posedge mclk) disable iff (rst)
		!rst |=> slp_rx_extend
		== ($past(slp_ext_src_sel) ? $past(cur.detect) : $past(cur.above)))
		else $error("receive extension source wrong");
	AST_WAKE_PULSE: assert property (@(posedge mclk) disable iff (rst)
		wake_event |=> !wake_event)
		else $error("wake longer than one cycle");
	AST_TIMER_OFF: assert property (@(posedge mclk) disable iff (rst)
		!sleep_timer_en |=> !wake_event)
		else $error("wake while timer disabled");
	AST_LOAD_OUTSIDE: assert property (@(posedge mclk) disable iff (rst)
		!rst && chip_state != csw_pkg::ST_SLEEP |=> cur.sleep_cnt == $past(sleep_interval))
		else $error("timer not held loaded");
	AST_CAL_BUSY: assert property (@(posedge mclk) disable iff (rst)
		cal_busy == (cur.cal_state != csw_pkg::CSW_CAL_DONE))
		else $error("busy flag disagrees with calibration");
	AST_CAL_HOLD: assert property (@(posedge mclk) disable iff (rst)
		cur.cal_state == csw_pkg::CSW_CAL_DONE |=> $stable(osc_trim))
		else $error("trim moved outside calibration");
	AST_LIVE: assert property (@(posedge mclk) disable iff (rst)
		!rst && !strength_capture_mode |=> strength_value == $past(rssi_clamped))
		else $error("live strength not followed");
	AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (rst)
		strength_capture_mode && !packet_stage_strobe |=> $stable(strength_value))
		else $error("latched strength moved");
	AST_DOUT_OFF: assert property (@(posedge mclk) disable iff (rst)
		!direct_mode |=> !demod_data_out)
		else $error("data out outside direct mode");
	// mute must not hide data when it is clear; checks the pass path too
	AST_DOUT_PASS: assert property (@(posedge mclk) disable iff (rst)
		!rst && direct_mode && !dout_mute |=> demod_data_out == $past(cur.sym_s2))
		else $error("direct data not passed");
endmodule

// ---- verification/csw_host_model.sv ----
// host model that holds and rewrites the radio configuration
`timescale 1ns/1ns
module csw_host_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] win_req,
	input wire logic signed [7:0] thr_req,
	output logic [1:0] jump_window_select,
	output logic signed [7:0] strength_threshold
);
	always_ff @(posedge mclk) begin
		if (rst) begin
			jump_window_select <= 2'h2; // four jumps unless rx time is short
			strength_threshold <= 8'sh00; // every reset wipes config, so rewrite it all
		end else begin
			jump_window_select <= win_req;
			strength_threshold <= thr_req;
		end
	end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the channel sense and wake block
`timescale 1ns/1ns
module tb;
	typedef struct {int unsigned due; int sel; logic [7:0] exp;} csw_note_s;
	localparam int DIV = 4;
	csw_note_s notes[$];
	csw_note_s n;
	int unsigned cyc = 0;
	int err_count = 0, checked = 0, r, t, i, j, k, rc;
	logic [7:0] gap = 8'h00, osc_measured_ticks = 8'h20, osc_trim;
	logic mclk = 1'b0, rst = 1'b1, sleep_timer_en = 1'b0, supply_low_in = 1'b0;
	logic [37:0] sleep_interval = 38'h1;
	logic [2:0] chip_state = 3'h2;
	logic signed [7:0] rssi_in = 8'sh00, thr_req = 8'sh00, strength_threshold, strength_value;
	logic strength_capture_mode = 1'b0, packet_stage_strobe = 1'b0, demod_symbol = 1'b0;
	logic symbol_strobe = 1'b0, deviation_ok = 1'b0, valid_irq_src_sel = 1'b0;
	logic slp_ext_src_sel = 1'b0, direct_mode = 1'b0, dout_mute = 1'b0;
	logic [1:0] demod_type = 2'h0, win_req = 2'h2, jump_window_select;
	logic [5:0] snr_db = 6'h00;
	logic wake_event, supply_level_result, strength_above, phase_jump_detector;
	logic signal_valid_irq, slp_rx_extend, demod_data_out;

	csw_host_model host (.mclk, .rst, .win_req, .thr_req, .jump_window_select,
		.strength_threshold);
	csw_channel_sense #(.LOW_POWER_OSC_DIV(DIV), .CAL_PERIOD_TICKS(8)) DUT (.mclk, .rst,
		.sleep_timer_en, .sleep_interval, .chip_state, .supply_low_in, .rssi_in,
		.strength_capture_mode, .packet_stage_strobe, .strength_threshold, .demod_type,
		.demod_symbol, .symbol_strobe, .deviation_ok, .snr_db, .jump_window_select,
		.valid_irq_src_sel, .slp_ext_src_sel, .direct_mode, .dout_mute,
		.osc_measured_ticks, .wake_event, .cal_busy(), .osc_trim, .supply_level_result,
		.strength_value, .strength_above, .phase_jump_detector, .signal_valid_irq,
		.slp_rx_extend, .demod_data_out);

	always #5 mclk = ~mclk;

	function automatic logic [7:0] obs(input int s);
		case (s)
			0: obs = osc_trim;
			1: obs = {7'h0, strength_above};
			2: obs = {7'h0, signal_valid_irq};
			3: obs = {7'h0, slp_rx_extend};
			4: obs = strength_value;
			5: obs = {7'h0, supply_level_result};
			6: obs = {7'h0, phase_jump_detector};
			7: obs = {7'h0, demod_data_out};
			default: obs = gap;
		endcase
	endfunction

	task wrap_up;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// counted on the falling edge so drivers and watcher read one stable value
	always @(negedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			wrap_up();
		end
	end

	always @(posedge mclk) begin
		#2;
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			n = notes.pop_front();
			checked++;
			if (obs(n.sel) !== n.exp) begin
				err_count++;
				$display("wrong value at %0t: got %h expected %h", $time, obs(n.sel), n.exp);
			end
		end
	end

	task step(input int c);
		repeat (c) @(posedge mclk);
	endtask

	task note(input int s, input logic [7:0] e, input int d);
		notes.push_back('{cyc + d, s, e});
	endtask

	// symbol settles through the synchroniser before its strobe
	task sym(input logic b);
		@(posedge mclk) demod_symbol <= b;
		step(4);
		symbol_strobe <= 1'b1;
		@(posedge mclk) symbol_strobe <= 1'b0;
		step(3);
	endtask

	task wake_gap(output int c);
		c = 0;
		// looked at mid-cycle so the pulse is seen while it stands
		do begin
			@(negedge mclk);
			c++;
		end while (wake_event !== 1'b1 && c < 400);
		@(posedge mclk);
	endtask

	initial begin
		r = $urandom(32'h9108);
		osc_measured_ticks <= 8'($urandom_range(33, 31));
		step(5);
		note(0, 8'h80, 1);
		@(posedge mclk) rst <= 1'b0;
		for (i = 0; i < 24; i++) begin
			r = (i == 0) ? -127 : (i == 1) ? 20 : int'($urandom_range(255)) - 128;
			t = (i == 2) ? r : int'($urandom_range(147)) - 127;
			rc = (r < csw_pkg::RSSI_MIN_DBM) ? csw_pkg::RSSI_MIN_DBM : r;
			rc = (rc > csw_pkg::RSSI_MAX_DBM) ? csw_pkg::RSSI_MAX_DBM : rc;
			@(posedge mclk) thr_req <= 8'(t);
			@(posedge mclk) rssi_in <= 8'(r);
			note(1, 8'(rc > t), 1);
			note(4, 8'(rc), 1);
			note(2, 8'(rc > t), 2);
			note(3, 8'(rc > t), 2);
		end
		@(posedge mclk) strength_capture_mode <= 1'b1;
		rssi_in <= 8'hd8;
		packet_stage_strobe <= 1'b1;
		@(posedge mclk) packet_stage_strobe <= 1'b0;
		rssi_in <= 8'h10;
		step(3);
		note(4, 8'hd8, 0);
		strength_capture_mode <= 1'b0;
		note(4, 8'h10, 3);
		for (k = 3; k <= 6; k++) begin
			chip_state <= (k[0]) ? csw_pkg::ST_SLEEP : csw_pkg::ST_STANDBY_STATE;
			supply_low_in <= k[0];
			step(6);
			chip_state <= 3'(k);
			step(3);
			note(5, 8'(k[0]), 0);
		end
		deviation_ok <= 1'b1;
		snr_db <= 6'h0a;
		demod_type <= csw_pkg::DEMOD_2FSK;
		for (k = 0; k < 4; k++) begin
			win_req <= 2'(k);
			sym(1'b0);
			chip_state <= csw_pkg::ST_SLEEP;
			step(3);
			chip_state <= csw_pkg::ST_RX;
			sym(1'b0);
			note(6, 8'h00, 0);
			for (j = 1; j <= (1 << k); j++) begin
				sym(j[0]);
				note(6, 8'(j == (1 << k)), 0);
			end
		end
		valid_irq_src_sel <= 1'b1;
		slp_ext_src_sel <= 1'b1;
		direct_mode <= 1'b1;
		dout_mute <= 1'b1;
		step(4);
		note(2, 8'h01, 0);
		note(3, 8'h01, 0);
		sym(1'b1);
		note(7, 8'h01, 0);
		snr_db <= 6'h07;
		sym(1'b0);
		note(6, 8'h00, 0);
		sym(1'b1);
		note(7, 8'h00, 0);
		dout_mute <= 1'b0;
		step(4);
		note(7, 8'h01, 0);
		snr_db <= 6'h0a;
		deviation_ok <= 1'b0;
		sym(1'b0);
		note(6, 8'h00, 0);
		deviation_ok <= 1'b1;
		demod_type <= csw_pkg::DEMOD_OOK;
		sym(1'b1);
		note(6, 8'h00, 0);
		for (k = 1; k <= 3; k += 2) begin
			sleep_interval <= 38'(k);
			sleep_timer_en <= 1'b1;
			chip_state <= csw_pkg::ST_SLEEP;
			wake_gap(j);
			wake_gap(j);
			wake_gap(j);
			gap <= 8'(j);
			note(8, 8'(DIV * k), 1);
			step(1);
		end
		note(0, 8'h80, 0);
		step(2);
		wrap_up();
	end
endmodule
